// [inc/mxal_defines.vh]
// constants for the maximum-address-limit command block
// assumes a byte-wide task file and one command strobe per command
`ifndef MXAL_DEFINES_VH
`define MXAL_DEFINES_VH
`define MXAL_CMD_SET_MAX 8'hF9
`define MXAL_CMD_READ_MAX 8'hF8
`define MXAL_CMD_SET_FEAT 8'hEF
`define MXAL_FEAT_OFS_ON 8'h09
`define MXAL_FEAT_OFS_OFF 8'h89
`define MXAL_DH_LBA_BIT 6
`define MXAL_DH_DRV_BIT 4
`define MXAL_SC_PERSIST_BIT 0
`define MXAL_HEADS_BIG 8'h10
`define MXAL_HEADS_SMALL 8'h0F
`define MXAL_SPT_FIXED 8'h3F
`define MXAL_ERR_ABORTED_CMD_FLAG 2'h1
`define MXAL_ERR_IDNF 2'h2
`define MXAL_ERR_NONE 2'h0
`endif

// [logic/mxal_max_addr.v]
// command logic for setting the highest accessible address and reading the native maximum
// assumes the host loads the task file before pulsing cmd_valid, and that
// the nonvolatile store is modelled by a register kept across soft reset
`timescale 1ns/1ps
`default_nettype none
`include "mxal_defines.vh"

module mxal_max_addr #(
	parameter NATIVE_MAX_LBA = 28'h0FFFFFF,
	parameter BIG_VARIANT = 1,
	parameter DRIVE_ID = 1'b0
) (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	input wire hard_reset,
	// task file written by host
	input wire cmd_valid,
	input wire [7:0] cmd_code,
	input wire [7:0] command_subcode,
	input wire [7:0] count_and_persist_opt,
	input wire [7:0] addr_low_byte,
	input wire [7:0] addr_lower_mid_byte,
	input wire [7:0] addr_upper_mid_byte,
	input wire [7:0] drive_and_top_nibble,
	// current geometry from initialize device parameters
	input wire [7:0] cur_heads,
	input wire [7:0] sectors_per_track_now,
	// media access check
	input wire acc_valid,
	input wire [27:0] acc_first_lba,
	input wire [27:0] acc_last_lba,
	// command completion
	output reg done,
	output reg [1:0] err_code,
	output reg aborted_cmd_flag,
	output reg [7:0] ret_low_byte,
	output reg [7:0] ret_lower_mid_byte,
	output reg [7:0] ret_upper_mid_byte,
	output reg [7:0] ret_drive_and_top_nibble,
	// access verdict
	output reg acc_reject,
	// identify and state
	output reg [27:0] max_lba,
	output reg [15:0] ident_word1,
	output reg [15:0] ident_word54,
	output reg offset_mode
);

	localparam [7:0] HEADS = BIG_VARIANT ? `MXAL_HEADS_BIG :
		`MXAL_HEADS_SMALL;
	localparam [15:0] HS = HEADS * `MXAL_SPT_FIXED;
	localparam [7:0] HEAD_TOP = HEADS - 8'h01;

	reg [27:0] nv_max;
	reg nv_valid;
	reg nv_used;
	reg read_seen;
	reg vol_set;
	reg [27:0] next_lim;
	reg [1:0] next_err;
	reg [27:0] req_lim;
	reg [15:0] cyl;
	reg [15:0] cur_prod;
	reg [27:0] quot;
	reg [27:0] prod_lim;
	reg [15:0] cyl_top;
	reg [27:0] w1_full;
	reg [27:0] w54_full;

	wire first_drive = ~drive_and_top_nibble[`MXAL_DH_DRV_BIT];
	wire second_drive = drive_and_top_nibble[`MXAL_DH_DRV_BIT];
	wire sel = DRIVE_ID ? second_drive : first_drive;
	wire lba_mode = drive_and_top_nibble[`MXAL_DH_LBA_BIT];
	wire persist = count_and_persist_opt[`MXAL_SC_PERSIST_BIT];

	// --------------------------------------------------------------
	// decode of the requested limit
	// --------------------------------------------------------------
	always @* begin
		req_lim = 28'h0000000;
		quot = 28'h0000000;
		cyl = {addr_upper_mid_byte, addr_lower_mid_byte};
		if (lba_mode) begin
			req_lim = {drive_and_top_nibble[3:0], addr_upper_mid_byte,
				addr_lower_mid_byte, addr_low_byte};
			// round down to whole cylinders of the fixed geometry
			quot = (req_lim + 28'h0000001) / {12'h000, HS};
			cyl = quot[15:0];
		end
		prod_lim = {12'h000, cyl} * {12'h000, HS};
		next_lim = prod_lim - 28'h0000001;
		if (cyl == 16'h0000)
			next_lim = 28'h0000000;
		cyl_top = cyl - 16'h0001;
	end

	// --------------------------------------------------------------
	// verdict for the set command
	// --------------------------------------------------------------
	always @* begin
		next_err = `MXAL_ERR_NONE;
		if (!read_seen)
			next_err = `MXAL_ERR_ABORTED_CMD_FLAG;
		else if (persist && offset_mode)
			next_err = `MXAL_ERR_ABORTED_CMD_FLAG;
		else if (persist && nv_used)
			next_err = `MXAL_ERR_IDNF;
		else if (next_lim > NATIVE_MAX_LBA)
			next_err = `MXAL_ERR_ABORTED_CMD_FLAG;
	end

	// --------------------------------------------------------------
	// command execution
	// --------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (rst || hard_reset) begin
			done <= 1'b0;
			err_code <= `MXAL_ERR_NONE;
			aborted_cmd_flag <= 1'b0;
			ret_low_byte <= 8'h00;
			ret_lower_mid_byte <= 8'h00;
			ret_upper_mid_byte <= 8'h00;
			ret_drive_and_top_nibble <= 8'h00;
			read_seen <= 1'b0;
			offset_mode <= 1'b0;
			if (hard_reset) begin
				vol_set <= 1'b0;
				nv_used <= 1'b0;
			end
		end else begin
			done <= 1'b0;
			if (cmd_valid && sel) begin
				done <= 1'b1;
				err_code <= `MXAL_ERR_NONE;
				aborted_cmd_flag <= 1'b0;
				read_seen <= 1'b0;
				case (cmd_code)
				`MXAL_CMD_READ_MAX: begin
					read_seen <= 1'b1;
					ret_drive_and_top_nibble <= {1'b1, lba_mode, 1'b1,
						drive_and_top_nibble[4], NATIVE_MAX_LBA[27:24]};
					ret_upper_mid_byte <= NATIVE_MAX_LBA[23:16];
					ret_lower_mid_byte <= NATIVE_MAX_LBA[15:8];
					ret_low_byte <= NATIVE_MAX_LBA[7:0];
				end
				`MXAL_CMD_SET_MAX: begin
					err_code <= next_err;
					aborted_cmd_flag <= (next_err == `MXAL_ERR_ABORTED_CMD_FLAG);
					if (next_err == `MXAL_ERR_NONE) begin
						vol_set <= 1'b1;
						if (persist) begin
							nv_used <= 1'b1;
						end
						if (lba_mode) begin
							ret_drive_and_top_nibble <= {1'b1, 1'b1, 1'b1,
								drive_and_top_nibble[4], next_lim[27:24]};
							ret_upper_mid_byte <= next_lim[23:16];
							ret_lower_mid_byte <= next_lim[15:8];
							ret_low_byte <= next_lim[7:0];
						end else begin
							ret_drive_and_top_nibble <= {1'b1, 1'b0, 1'b1,
								drive_and_top_nibble[4], HEAD_TOP[3:0]};
							ret_upper_mid_byte <= cyl_top[15:8];
							ret_lower_mid_byte <= cyl_top[7:0];
							ret_low_byte <= `MXAL_SPT_FIXED;
						end
					end
				end
				`MXAL_CMD_SET_FEAT: begin
					if (command_subcode == `MXAL_FEAT_OFS_ON) begin
						if (nv_valid)
							offset_mode <= 1'b1;
						else begin
							err_code <= `MXAL_ERR_ABORTED_CMD_FLAG;
							aborted_cmd_flag <= 1'b1;
						end
					end else if (command_subcode == `MXAL_FEAT_OFS_OFF)
						offset_mode <= 1'b0;
				end
				default: begin
				end
				endcase
			end
		end
	end

	// --------------------------------------------------------------
	// limit storage: the nonvolatile copy ignores both resets
	// --------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (cmd_valid && sel && cmd_code == `MXAL_CMD_SET_MAX &&
			next_err == `MXAL_ERR_NONE && persist && !rst &&
			!hard_reset) begin
			nv_max <= next_lim;
			nv_valid <= 1'b1;
		end else if (nv_valid !== 1'b1) begin
			nv_max <= NATIVE_MAX_LBA;
			nv_valid <= 1'b0;
		end
	end

	reg [27:0] vol_max;
	always @(posedge clk_sys) begin
		// a soft reset keeps the volatile limit; only hard reset drops it
		if (hard_reset)
			vol_max <= 28'h0000000;
		else if (rst)
			vol_max <= vol_max;
		else if (cmd_valid && sel && cmd_code == `MXAL_CMD_SET_MAX &&
			next_err == `MXAL_ERR_NONE)
			vol_max <= next_lim;
	end

	// --------------------------------------------------------------
	// active limit, identify words and access checking
	// --------------------------------------------------------------
	always @* begin
		max_lba = vol_set ? vol_max : nv_max;
		cur_prod = {8'h00, cur_heads} * {8'h00, sectors_per_track_now};
		w1_full = max_lba / {12'h000, HS};
		ident_word1 = w1_full[15:0];
		w54_full = {12'h000, ident_word1};
		if (cur_prod == 16'h0000)
			w54_full = {12'h000, ident_word1};
		else if (lba_mode)
			w54_full = (max_lba + 28'h0000001) /
				{12'h000, cur_prod};
		else
			w54_full = ({12'h000, ident_word1} + 28'h0000001) *
				{12'h000, HS} / {12'h000, cur_prod};
		ident_word54 = w54_full[15:0];
	end

	always @(posedge clk_sys) begin
		if (rst)
			acc_reject <= 1'b0;
		else
			acc_reject <= acc_valid && (acc_first_lba > max_lba ||
				acc_last_lba > max_lba);
	end

endmodule // mxal_max_addr
`default_nettype wire

// [test/mxal_chk_sva.sv]
// checker for the max-address-limit block, bound to its top ports
// assumes the block is drive 0 of the large variant, one clock
`timescale 1ns/1ps
`default_nettype none
module mxal_chk #(parameter NATIVE_MAX_LBA = 28'h0FFFFFF) (
	// clock and resets
	input wire logic clk_sys, rst, hard_reset,
	// requests
	input wire logic cmd_valid, acc_valid,
	input wire logic [7:0] cmd_code, count_and_persist_opt,
	input wire logic [7:0] drive_and_top_nibble,
	input wire logic [27:0] acc_first_lba, acc_last_lba,
	// results
	input wire logic done, acc_reject, offset_mode,
	input wire logic [1:0] err_code,
	input wire logic [27:0] max_lba
);
	logic last_rd;
	wire logic tk = cmd_valid && !drive_and_top_nibble[4];
	wire logic tk_oth = cmd_valid && drive_and_top_nibble[4];
	wire logic nv_ofs = count_and_persist_opt[0] && offset_mode;
	wire logic past_lim = acc_first_lba > max_lba || acc_last_lba > max_lba;
	// any other command taken spoils the read-first record
	always @(posedge clk_sys)
		if (rst || hard_reset) last_rd <= 1'b0;
		else if (tk) last_rd <= cmd_code == 8'hF8;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst || hard_reset);
	sequence s_set;
		tk && cmd_code == 8'hF9;
	endsequence
	sequence s_set_ok;
		s_set ##1 done && err_code == 2'h0;
	endsequence
	a_done_next: assert property (tk |=> done)
		else $error("done late");
	a_other_drive: assert property (tk_oth |=> !done)
		else $error("other drive answered");
	a_read_first: assert property (s_set ##0 !last_rd |=> err_code == 2'h1)
		else $error("set without read not aborted");
	a_nv_offset: assert property (s_set ##0 nv_ofs |=> err_code == 2'h1)
		else $error("persistent set in offset mode");
	a_in_native: assert property (max_lba <= NATIVE_MAX_LBA)
		else $error("limit above native");
	a_reject_past: assert property (acc_valid && past_lim |=> acc_reject)
		else $error("access past limit accepted");
	a_accept_in: assert property (acc_valid && !past_lim |=> !acc_reject)
		else $error("access inside limit refused");
	// 16 heads of 63 sectors make one whole cylinder
	a_whole_cyl: assert property (s_set_ok |-> (max_lba + 28'h1) % 1008 == 0)
		else $error("limit not whole cylinders");
endmodule // mxal_chk
bind mxal_max_addr mxal_chk #(.NATIVE_MAX_LBA(NATIVE_MAX_LBA)) chk_u (.*);
`default_nettype wire

// [test/mxal_host.sv]
// host model that loads the task file and strobes one command
// assumes the drive samples on the rising edge; bytes stay loaded after
`timescale 1ns/1ps
`default_nettype none
module mxal_host (
	input wire logic clk_sys,
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic [7:0] command_subcode,
	output logic [7:0] count_and_persist_opt,
	output logic [7:0] drive_and_top_nibble,
	output logic [7:0] addr_upper_mid_byte,
	output logic [7:0] addr_lower_mid_byte,
	output logic [7:0] addr_low_byte
);
	initial begin
		cmd_valid = 1'b0;
		{cmd_code, command_subcode, count_and_persist_opt} = 24'h0;
		{drive_and_top_nibble, addr_upper_mid_byte} = 16'h0;
		{addr_lower_mid_byte, addr_low_byte} = 16'h0;
	end
	task send(input [7:0] c, s, p, input [3:0] d, input [27:0] l);
		@(negedge clk_sys);
		{cmd_code, command_subcode, count_and_persist_opt} = {c, s, p};
		{drive_and_top_nibble, addr_upper_mid_byte, addr_lower_mid_byte,
			addr_low_byte} = {d, l};
		cmd_valid = 1'b1;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
	endtask
endmodule // mxal_host
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the max-address-limit block
// assumes the host model drives the task file on falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [27:0] NAT = 28'h0FFFFFF;
	localparam logic [27:0] LIM = 28'h0011F6F;
	int error_cnt = 0;
	int total_checks = 0;
	logic clk_sys, rst, hard_reset, cmd_valid, acc_valid, done, acc_reject;
	logic aborted_cmd_flag, offset_mode;
	logic [1:0] err_code;
	logic [7:0] cmd_code, command_subcode, count_and_persist_opt, addr_low_byte;
	logic [7:0] addr_lower_mid_byte, addr_upper_mid_byte, drive_and_top_nibble;
	logic [7:0] cur_heads, sectors_per_track_now, ret_low_byte;
	logic [7:0] ret_lower_mid_byte, ret_upper_mid_byte, ret_drive_and_top_nibble;
	logic [27:0] acc_first_lba, acc_last_lba, max_lba;
	logic [15:0] ident_word1, ident_word54;
	wire logic [27:0] ret = {ret_drive_and_top_nibble[3:0], ret_upper_mid_byte,
		ret_lower_mid_byte, ret_low_byte};
	mxal_max_addr #(.NATIVE_MAX_LBA(NAT)) dut_u (.*);
	mxal_host host_u (.*);
	task chk(input string n, input logic [27:0] e, g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task cmd(input [7:0] c, s, p, input [3:0] d, input [27:0] l, input [1:0] e);
		host_u.send(c, s, p, d, l);
		chk("done", 28'h1, {27'h0, done});
		chk("err_code", {26'h0, e}, {26'h0, err_code});
	endtask
	task acc(input [27:0] f, l, input r);
		acc_first_lba = f;
		acc_last_lba = l;
		acc_valid = 1'b1;
		@(negedge clk_sys);
		acc_valid = 1'b0;
		chk("acc_reject", {27'h0, r}, {27'h0, acc_reject});
		@(negedge clk_sys);
	endtask
	task end_of_test;
		if (error_cnt == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// the whole run needs well under a thousand cycles
	initial begin
		#200000;
		error_cnt++;
		end_of_test;
	end
	initial begin
		{rst, hard_reset, acc_valid} = 3'h7;
		{acc_first_lba, acc_last_lba} = 56'h0;
		cur_heads = 8'h10;
		sectors_per_track_now = 8'h3F;
		repeat (6) @(negedge clk_sys);
		{rst, hard_reset, acc_valid} = 3'h0;
		cmd(8'hF9, 8'h00, 8'h00, 4'h4, 28'h0012164, 2'h1);
		chk("abort flag", 28'h1, {27'h0, aborted_cmd_flag});
		cmd(8'hF8, 8'h00, 8'h00, 4'h4, 28'h0, 2'h0);
		chk("native", NAT, ret);
		cmd(8'hF9, 8'h00, 8'h01, 4'h4, 28'h0012164, 2'h0);
		chk("max_lba", LIM, max_lba);
		chk("reply", LIM, ret);
		chk("word1", 28'h48, {12'h0, ident_word1});
		chk("word54", 28'h49, {12'h0, ident_word54});
		acc(28'h0, LIM, 1'b0);
		acc(LIM, LIM + 28'h1, 1'b1);
		cmd(8'hF8, 8'h00, 8'h00, 4'h4, 28'h0, 2'h0);
		cmd(8'hF9, 8'h00, 8'h01, 4'h4, 28'h0012164, 2'h2);
		cmd(8'hF8, 8'h00, 8'h00, 4'h4, 28'h0, 2'h0);
		cmd(8'hF9, 8'h00, 8'h00, 4'h4, 28'h00007E5, 2'h0);
		chk("max_lba", 28'h00007DF, max_lba);
		hard_reset = 1'b1;
		@(negedge clk_sys);
		hard_reset = 1'b0;
		chk("max_lba", LIM, max_lba);
		cmd(8'hEF, 8'h09, 8'h00, 4'h4, 28'h0, 2'h0);
		chk("offset", 28'h1, {27'h0, offset_mode});
		cmd(8'hF8, 8'h00, 8'h00, 4'h4, 28'h0, 2'h0);
		cmd(8'hF9, 8'h00, 8'h01, 4'h4, 28'h0012164, 2'h1);
		rst = 1'b1;
		@(negedge clk_sys);
		rst = 1'b0;
		chk("offset", 28'h0, {27'h0, offset_mode});
		chk("max_lba", LIM, max_lba);
		host_u.send(8'hF8, 8'h00, 8'h00, 4'h5, 28'h0);
		chk("done", 28'h0, {27'h0, done});
		cmd(8'hF8, 8'h00, 8'h00, 4'h4, 28'h0, 2'h0);
		cmd(8'hEF, 8'h89, 8'h00, 4'h4, 28'h0, 2'h0);
		cmd(8'hF9, 8'h00, 8'h00, 4'h4, 28'h00007E5, 2'h1);
		cmd(8'hF8, 8'h00, 8'h00, 4'h0, 28'h0, 2'h0);
		cmd(8'hF9, 8'h00, 8'h00, 4'h0, 28'h0000A00, 2'h0);
		chk("chs reply", 28'hF00093F, ret);
		chk("word54", 28'hA, {12'h0, ident_word54});
		end_of_test;
	end
endmodule // tb_top
`default_nettype wire
